// ---- inc/aie_pkg.sv ----
// package: encodings, field positions and phase states for the add execute block
package aie_pkg;
    localparam int DATA_W = 8;
    localparam int INSTR_W = 14;
    localparam int ADDR_W = 7;
    // literal add: 11 111x kkkk kkkk
    localparam logic [4:0] LIT_ADD_PAT = 5'h1f;
    localparam int LIT_PAT_HI = 13;
    localparam int LIT_PAT_LO = 9;
    // file add: 00 0111 dfff ffff
    localparam logic [5:0] FILE_ADD_PAT = 6'h07;
    localparam int FILE_PAT_HI = 13;
    localparam int FILE_PAT_LO = 8;
    localparam int DEST_BIT = 7;
    localparam int DIGIT_BIT = 3;
    localparam logic [7:0] ACC_RESET = 8'h00;
    typedef enum logic [1:0] {
        AIE_DECODE,
        AIE_READ,
        AIE_PROCESS,
        AIE_WRITE
    } aie_phase_t;
    typedef enum logic [1:0] {
        AIE_OP_NONE,
        AIE_OP_LIT,
        AIE_OP_FILE
    } aie_op_t;
endpackage

// ---- rtl/aie_adder.sv ----
// 8-bit adder giving sum, carry out of bit 7 and digit carry out of bit 3
`timescale 1ns/1ps
module aie_adder #(
    parameter int WIDTH = 8,
    parameter int DIGIT = 3
) (
    input wire logic [WIDTH-1:0] a,
    input wire logic [WIDTH-1:0] b,
    output logic [WIDTH-1:0] sum,
    output logic carry,
    output logic digit_carry
);
    logic [WIDTH:0] full;
    logic [DIGIT+1:0] low;
    always_comb begin
        full = {1'b0, a} + {1'b0, b};
        low = {1'b0, a[DIGIT:0]} + {1'b0, b[DIGIT:0]};
        sum = full[WIDTH-1:0];
        carry = full[WIDTH];
        digit_carry = low[DIGIT+1];
    end
endmodule

// ---- rtl/aie_add_execute.sv ----
// execute stage for the literal add and the file add, one instruction per four phases
`timescale 1ns/1ps
// Notes on behaviour
// RQ1: literal-add pattern adds low-byte literal to accumulator; bit 8 ignored.
// RQ2: literal add reads literal in phase two, sums in three, writes in four.
// RQ3: file-add pattern adds accumulator to 7-bit addressed file register; bit 7 selects destination.
// RQ4: destination bit clear: sum to accumulator, file register untouched.
// RQ5: destination bit set: sum to file register, accumulator untouched.
// RQ6: file add reads register in phase two, sums in three, writes in four.
// RQ7: carry from bit 7, digit carry from bit 3, zero when result zero.
// RQ8: every instruction cycle is decode, read, process, write phases in turn.
module aie_add_execute
    import aie_pkg::*;
#(
    parameter int AW = aie_pkg::ADDR_W
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [aie_pkg::INSTR_W-1:0] instr,
    output logic [AW-1:0] file_addr,
    output logic file_rd,
    input wire logic [aie_pkg::DATA_W-1:0] file_rdata,
    output logic file_wr,
    output logic [aie_pkg::DATA_W-1:0] file_wdata,
    output logic [aie_pkg::DATA_W-1:0] accumulator,
    output logic carry_flag,
    output logic digit_carry_flag,
    output logic zero_flag,
    output logic flags_wr,
    output aie_pkg::aie_phase_t phase,
    output logic write_phase
);
    import aie_pkg::*;

    // ==========================================================
    // phase sequencer
    aie_phase_t phase_reg, phase_next;
    always_comb begin
        case (phase_reg)
            AIE_DECODE: phase_next = AIE_READ; // [RQ8]
            AIE_READ: phase_next = AIE_PROCESS; // [RQ8]
            AIE_PROCESS: phase_next = AIE_WRITE; // [RQ8]
            AIE_WRITE: phase_next = AIE_DECODE; // [RQ8]
            default: phase_next = AIE_DECODE;
        endcase
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            phase_reg <= AIE_DECODE;
        end else begin
            phase_reg <= phase_next;
        end
    end
    assign phase = phase_reg;
    assign write_phase = (phase_reg == AIE_WRITE);

    // ==========================================================
    // decode
    function automatic aie_op_t decode_op(input logic [INSTR_W-1:0] iw);
        if (iw[LIT_PAT_HI:LIT_PAT_LO] == LIT_ADD_PAT) begin
            decode_op = AIE_OP_LIT; // [RQ1]
        end else if (iw[FILE_PAT_HI:FILE_PAT_LO] == FILE_ADD_PAT) begin
            decode_op = AIE_OP_FILE; // [RQ3]
        end else begin
            decode_op = AIE_OP_NONE;
        end
    endfunction

    // ==========================================================
    // datapath state
    aie_op_t op_reg, op_next;
    logic dest_reg, dest_next;
    logic [AW-1:0] addr_reg, addr_next;
    logic [DATA_W-1:0] opnd_reg, opnd_next;
    logic [DATA_W-1:0] sum_reg, sum_next;
    logic c_res_reg, c_res_next, dc_res_reg, dc_res_next;
    logic [DATA_W-1:0] acc_reg, acc_next;
    logic [DATA_W-1:0] wdata_reg, wdata_next;
    logic fwr_reg, fwr_next;
    logic cf_reg, cf_next, dcf_reg, dcf_next, zf_reg, zf_next;
    logic flw_reg, flw_next;
    logic [DATA_W-1:0] add_sum;
    logic add_c, add_dc;

    aie_adder #(
        .WIDTH(DATA_W),
        .DIGIT(DIGIT_BIT)
    ) u_adder (
        .a(acc_reg),
        .b(opnd_reg),
        .sum(add_sum),
        .carry(add_c),
        .digit_carry(add_dc)
    );

    always_comb begin
        op_next = op_reg;
        dest_next = dest_reg;
        addr_next = addr_reg;
        opnd_next = opnd_reg;
        sum_next = sum_reg;
        c_res_next = c_res_reg;
        dc_res_next = dc_res_reg;
        acc_next = acc_reg;
        wdata_next = wdata_reg;
        fwr_next = 1'b0;
        cf_next = cf_reg;
        dcf_next = dcf_reg;
        zf_next = zf_reg;
        flw_next = 1'b0;
        case (phase_reg)
            AIE_DECODE: begin
                op_next = decode_op(instr); // [RQ1] [RQ3]
                dest_next = instr[DEST_BIT]; // [RQ3]
                addr_next = instr[AW-1:0]; // [RQ3]
            end
            AIE_READ: begin
                if (op_reg == AIE_OP_LIT) begin
                    opnd_next = instr[DATA_W-1:0]; // [RQ2]
                end else if (op_reg == AIE_OP_FILE) begin
                    opnd_next = file_rdata; // [RQ6]
                end
            end
            AIE_PROCESS: begin
                sum_next = add_sum; // [RQ2] [RQ6]
                c_res_next = add_c; // [RQ7]
                dc_res_next = add_dc; // [RQ7]
                // prepare file data a phase early so it comes from a flop in the write phase
                if (op_reg == AIE_OP_FILE && dest_reg) begin
                    wdata_next = add_sum; // [RQ5]
                    fwr_next = 1'b1; // [RQ5]
                end
            end
            AIE_WRITE: begin
                if (op_reg == AIE_OP_LIT || (op_reg == AIE_OP_FILE && !dest_reg)) begin
                    acc_next = sum_reg; // [RQ1] [RQ2] [RQ4]
                end
                if (op_reg != AIE_OP_NONE) begin
                    cf_next = c_res_reg; // [RQ7]
                    dcf_next = dc_res_reg; // [RQ7]
                    zf_next = (sum_reg == '0); // [RQ7]
                    flw_next = 1'b1;
                end
            end
            default: begin
                op_next = AIE_OP_NONE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            op_reg <= AIE_OP_NONE;
            dest_reg <= 1'b0;
            addr_reg <= '0;
            opnd_reg <= '0;
            sum_reg <= '0;
            c_res_reg <= 1'b0;
            dc_res_reg <= 1'b0;
            acc_reg <= ACC_RESET;
            wdata_reg <= '0;
            fwr_reg <= 1'b0;
            cf_reg <= 1'b0;
            dcf_reg <= 1'b0;
            zf_reg <= 1'b0;
            flw_reg <= 1'b0;
        end else begin
            op_reg <= op_next;
            dest_reg <= dest_next;
            addr_reg <= addr_next;
            opnd_reg <= opnd_next;
            sum_reg <= sum_next;
            c_res_reg <= c_res_next;
            dc_res_reg <= dc_res_next;
            acc_reg <= acc_next;
            wdata_reg <= wdata_next;
            fwr_reg <= fwr_next;
            cf_reg <= cf_next;
            dcf_reg <= dcf_next;
            zf_reg <= zf_next;
            flw_reg <= flw_next;
        end
    end

    // ==========================================================
    // outputs
    assign file_addr = addr_reg;
    assign file_rd = (phase_reg == AIE_READ) && (op_reg == AIE_OP_FILE); // [RQ6]
    assign file_wr = fwr_reg; // [RQ5]
    assign file_wdata = wdata_reg;
    assign accumulator = acc_reg;
    assign carry_flag = cf_reg;
    assign digit_carry_flag = dcf_reg;
    assign zero_flag = zf_reg;
    assign flags_wr = flw_reg;

    // ==========================================================
    // checks
    property p_phase_order;
        @(posedge core_clk) disable iff (!nrst)
        phase_reg == AIE_DECODE |=> phase_reg == AIE_READ ##1 phase_reg == AIE_PROCESS ##1 phase_reg == AIE_WRITE;
    endproperty
    a_phase_order: assert property (p_phase_order) else $error("phase sequence broken"); // [RQ8]

    property p_lit_acc;
        @(posedge core_clk) disable iff (!nrst)
        (phase_reg == AIE_DECODE && instr[13:9] == 5'h1f) ##1 (phase_reg == AIE_READ)[*1]
        |=> ##1 (phase_reg == AIE_WRITE) ##1 accumulator == 8'($past(acc_reg, 3) + $past(instr[DATA_W-1:0], 3));
    endproperty
    a_lit_acc: assert property (p_lit_acc) else $error("literal add result wrong"); // [RQ1]

    property p_lit_write_phase;
        @(posedge core_clk) disable iff (!nrst)
        $changed(acc_reg) |-> $past(phase_reg) == AIE_WRITE;
    endproperty
    a_lit_write_phase: assert property (p_lit_write_phase) else $error("accumulator changed outside write"); // [RQ2]

    property p_file_read;
        @(posedge core_clk) disable iff (!nrst)
        (phase_reg == AIE_DECODE && instr[13:8] == 6'h07) |=> file_rd && file_addr == $past(instr[6:0]);
    endproperty
    a_file_read: assert property (p_file_read) else $error("file read not issued in read phase"); // [RQ3]

    property p_dest_acc;
        @(posedge core_clk) disable iff (!nrst)
        (phase_reg == AIE_DECODE && instr[13:8] == 6'h07 && !instr[7]) |-> ##1 !file_wr [*3];
    endproperty
    a_dest_acc: assert property (p_dest_acc) else $error("file written for accumulator destination"); // [RQ4]

    property p_dest_file;
        @(posedge core_clk) disable iff (!nrst)
        (phase_reg == AIE_DECODE && instr[13:8] == 6'h07 && instr[7]) |-> ##3 file_wr ##1 $stable(acc_reg);
    endproperty
    a_dest_file: assert property (p_dest_file) else $error("file destination handled wrongly"); // [RQ5]

    property p_file_wr_phase;
        @(posedge core_clk) disable iff (!nrst)
        file_wr |-> write_phase && file_wdata == 8'($past(file_rdata, 2) + accumulator);
    endproperty
    a_file_wr_phase: assert property (p_file_wr_phase) else $error("file write outside write phase"); // [RQ6]

    property p_zero;
        @(posedge core_clk) disable iff (!nrst)
        flags_wr |-> zero_flag == ($past(sum_reg) == 8'h00) && carry_flag == $past(c_res_reg)
            && digit_carry_flag == $past(dc_res_reg);
    endproperty
    a_zero: assert property (p_zero) else $error("flag update wrong"); // [RQ7]

    c_lit: cover property (@(posedge core_clk) disable iff (!nrst) flags_wr && op_reg == AIE_OP_LIT);
    c_file_w: cover property (@(posedge core_clk) disable iff (!nrst) flags_wr && op_reg == AIE_OP_FILE && !dest_reg);
    c_file_f: cover property (@(posedge core_clk) disable iff (!nrst) file_wr);
    c_carry: cover property (@(posedge core_clk) disable iff (!nrst) flags_wr && carry_flag && zero_flag);
endmodule

// ---- verification/aie_file_model.sv ----
// far-side file register model for the add execute block
`timescale 1ns/1ps
module aie_file_model (
    input wire logic core_clk,
    input wire logic [6:0] file_addr,
    input wire logic file_rd,
    output logic [7:0] file_rdata,
    input wire logic file_wr,
    input wire logic [7:0] file_wdata
);
    logic [7:0] mem [0:127];
    logic [7:0] last_reg;
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'(i * 5 + 3);
        end
        last_reg = 8'h00;
    end
    // ==========
    // write port and read bus
    always @(posedge core_clk) begin
        if (file_wr) begin
            mem[file_addr] <= file_wdata;
        end
        if (file_rd) begin
            last_reg <= mem[file_addr];
        end
    end
    // released bus shows the inverse so a late sample cannot pass by luck
    assign file_rdata = file_rd ? mem[file_addr] : ~last_reg;
endmodule

// ---- verification/add_instruction_execute_tb_top.sv ----
// self-checking bench for the add execute block
`timescale 1ns/1ps
module add_instruction_execute_tb_top;
    import aie_pkg::*;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [13:0] instr = 14'h0000;
    logic [6:0] file_addr;
    logic file_rd, file_wr, carry_flag, digit_carry_flag, zero_flag, flags_wr, write_phase;
    logic [7:0] file_rdata, file_wdata, accumulator;
    aie_phase_t phase;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [7:0] acc_m = 8'h00;
    logic [2:0] fl_m = 3'h0;
    logic [13:0] prog [0:9] = '{14'h3e10, 14'h3f15, 14'h3edb, 14'h0705, 14'h0785,
                                14'h07ff, 14'h3905, 14'h0000, 14'h3e0f, 14'h3ef1};
    always #10 core_clk = ~core_clk;
    aie_add_execute dut (.core_clk(core_clk), .nrst(nrst), .instr(instr), .file_addr(file_addr),
        .file_rd(file_rd), .file_rdata(file_rdata), .file_wr(file_wr), .file_wdata(file_wdata),
        .accumulator(accumulator), .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag),
        .zero_flag(zero_flag), .flags_wr(flags_wr), .phase(phase), .write_phase(write_phase));
    aie_file_model part (.core_clk(core_clk), .file_addr(file_addr), .file_rd(file_rd),
        .file_rdata(file_rdata), .file_wr(file_wr), .file_wdata(file_wdata));
    // ==========
    // checking and closing
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles > 2000) begin
            miscompares++;
            report_and_stop();
        end
    end
    // ==========
    // one instruction cycle, entered at the falling edge of a decode phase
    task automatic run(input logic [13:0] iw);
        logic lit, fil, d;
        logic [6:0] a;
        logic [7:0] opnd, s;
        logic c, dc;
        lit = (iw[13:9] == 5'h1f);
        fil = (iw[13:8] == 6'h07);
        d = iw[7];
        a = iw[6:0];
        opnd = lit ? iw[7:0] : part.mem[a];
        {c, s} = 9'(acc_m) + 9'(opnd);
        dc = (5'(acc_m[3:0]) + 5'(opnd[3:0])) > 5'h0f;
        instr = iw;
        chk("decode", 8'(phase), 8'(AIE_DECODE));
        @(negedge core_clk);
        chk("read", 8'(phase), 8'(AIE_READ));
        chk("file_rd", 8'(file_rd), 8'(fil));
        if (fil) chk("file_addr", 8'(file_addr), 8'(a));
        @(negedge core_clk);
        chk("process", 8'(phase), 8'(AIE_PROCESS));
        @(negedge core_clk);
        chk("write_phase", 8'(write_phase), 8'h01);
        chk("file_wr", 8'(file_wr), 8'(fil && d));
        if (fil && d) chk("file_wdata", file_wdata, s);
        chk("acc_hold", accumulator, acc_m);
        @(negedge core_clk);
        chk("flags_wr", 8'(flags_wr), 8'(lit || fil));
        if (lit || fil) fl_m = {c, dc, s == 8'h00};
        if (lit || (fil && !d)) acc_m = s;
        if (fil) chk("file_reg", part.mem[a], d ? s : opnd);
        chk("accumulator", accumulator, acc_m);
        chk("flags", 8'({carry_flag, digit_carry_flag, zero_flag}), 8'(fl_m));
    endtask
    // ==========
    // main sequence
    initial begin
        repeat (10) @(negedge core_clk);
        chk("acc_reset", accumulator, ACC_RESET);
        nrst = 1'b1;
        foreach (prog[i]) begin
            run(prog[i]);
        end
        report_and_stop();
    end
endmodule
